// file: verilog/scp_regs.vh
// constants for the serial card port decode and rate select block
// assumes a 32-bit apb slave at 100 mhz, word-aligned registers
`ifndef SCP_REGS_VH
`define SCP_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SCP_OFF_BASE 12'h000
`define SCP_OFF_ROUTE 12'h004
`define SCP_OFF_RATE_A 12'h008
`define SCP_OFF_RATE_B 12'h00c
`define SCP_OFF_STATUS 12'h010
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SCP_ROUTE_A_MODEM 0
`define SCP_ROUTE_B_MODEM 1
`define SCP_ROUTE_B_LOOP 2
`define SCP_BASE_RESET 6'h2c
`define SCP_RATE_RESET 10'h200
`define SCP_ROUTE_RESET 3'h2
`endif

// file: verilog/scp_chan_route.v
// one channel's connector pin routing and rate code
// assumes one-hot rate select and synchronous pin inputs
module scp_chan_route (
   input wire pclk, // clock
   input wire presetn, // async reset, active low
   input wire modem, // 1 = modem routing
   input wire [9:0] rate_select, // one-hot rate select
   input wire txd, // controller transmit data
   input wire rts, // controller request to send
   input wire dtr, // controller terminal ready
   input wire pin2_in, // pin 2 level in
   input wire pin3_in, // pin 3 level in
   input wire pin4_in, // pin 4 level in
   input wire pin5_in, // pin 5 level in
   input wire pin6_in, // pin 6 level in
   input wire pin7_in, // pin 7 level in
   output reg [7:2] pin_out, // pins 2..7 drive value
   output reg [7:2] pin_oe, // pins 2..7 drive enable
   output reg rxd, // to controller
   output reg cts, // to controller
   output reg dcd, // to controller
   output reg [3:0] rate_code, // 1..10, 0 when select invalid
   output reg rate_err // not exactly one select active
);
   reg [3:0] next_code;
   reg [3:0] cnt;
   integer i;
   // ----------------------------------------
   // rate decode
   // ----------------------------------------
   // one-hot decode
   always @* begin
      next_code = 4'h0;
      cnt = 4'h0;
      for (i = 0; i < 10; i = i + 1) begin
         if (rate_select[i]) begin
            next_code = i[3:0] + 4'h1;
            cnt = cnt + 4'h1;
         end
      end
      if (cnt != 4'h1) next_code = 4'h0;
   end
   // ----------------------------------------
   // routing
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out <= 6'h00;
         pin_oe <= 6'h00;
         rxd <= 1'b1;
         cts <= 1'b0;
         dcd <= 1'b0;
         rate_code <= 4'h0;
         rate_err <= 1'b0;
      end else begin
         rate_code <= next_code;
         rate_err <= (cnt != 4'h1);
         // pairs swapped in modem routing
         // modem: drive 3 txd, 5 rts, 7 dtr; read 2, 4, 6
         if (modem) begin
            pin_out <= {dtr, 1'b0, rts, 1'b0, txd, 1'b0};
            pin_oe <= 6'b101010;
            rxd <= pin2_in;
            cts <= pin4_in;
            dcd <= pin6_in;
         end else begin
            // terminal: drive 2 txd, 4 rts, 6 dtr; read 3, 5, 7
            pin_out <= {1'b0, dtr, 1'b0, rts, 1'b0, txd};
            pin_oe <= 6'b010101;
            rxd <= pin3_in;
            cts <= pin5_in;
            dcd <= pin7_in;
         end
      end
   end
endmodule

// file: verilog/scp_port_decode.v
// host port decode, channel routing and rate select for a two-channel serial card
// assumes host i/o strobes and address are synchronous to pclk, apb master for setup
// Functional notes
// - the card answers a block of four ports based on address bits 7..2
// - claim only when address bits 7..2 equal the six match-setting levels
// - a closed match position reads 0, an open one reads 1
// - factory match setting places the card at ports b0h to b3h
// - address bit 1 picks channel, bit 0 picks data or control
// - each channel has its own rate out of ten fixed rates
// - ten one-hot inputs per channel pick the rate in ascending order
// - channel a routes terminal or modem; b adds current loop
// - modem routing swaps each pin pair and reverses its direction
// - channel b picks voltage or current loop apart from its routing
// - channel a defaults to terminal routing
// - channel b defaults to modem routing with voltage signalling
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`include "scp_regs.vh"
module scp_port_decode (
   input wire pclk, // clock, 100 mhz
   input wire presetn, // async reset, active low
   input wire [11:0] paddr, // apb address
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr, // apb error
   input wire [7:0] host_addr, // host i/o address
   input wire host_iorq_n, // host i/o request, active low
   input wire host_mreq_n, // host memory request, active low
   input wire host_rd_n, // host read, active low
   input wire host_wr_n, // host write, active low
   output reg ctl_cs_n, // controller select, active low
   output reg ctl_chan_b, // 1 = channel b
   output reg ctl_ctrl, // 1 = control word, 0 = data
   input wire [9:0] chan_a_rate_select, // channel a one-hot rate
   input wire [9:0] chan_b_rate_select, // channel b one-hot rate
   input wire a_txd, // controller a transmit data
   input wire a_rts, // controller a rts
   input wire a_dtr, // controller a dtr
   input wire b_txd, // controller b transmit data
   input wire b_rts, // controller b rts
   input wire b_dtr, // controller b dtr
   input wire [7:2] a_pin_in, // channel a pins 2..7 in
   input wire [7:2] b_pin_in, // channel b pins 2..7 in
   output reg [7:2] a_pin_out, // channel a pins 2..7 out
   output reg [7:2] a_pin_oe, // channel a pins 2..7 enable
   output reg [7:2] b_pin_out, // channel b pins 2..7 out
   output reg [7:2] b_pin_oe, // channel b pins 2..7 enable
   output reg a_rxd, // to controller a
   output reg a_cts, // to controller a
   output reg a_dcd, // to controller a
   output reg b_rxd, // to controller b
   output reg b_cts, // to controller b
   output reg b_dcd, // to controller b
   output reg [3:0] a_rate_code, // channel a rate index 1..10, 0 when select invalid
   output reg [3:0] b_rate_code // channel b rate index 1..10, 0 when select invalid
);
   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   // match levels: bit set = open position = logic 1
   reg [5:0] port_base_match_setting;
   reg [2:0] route;
   reg hit_seen;
   wire [5:0] ra_out, ra_oe, rb_out, rb_oe;
   wire ra_rxd, ra_cts, ra_dcd, rb_rxd, rb_cts, rb_dcd;
   wire [3:0] ra_code, rb_code;
   wire ra_err, rb_err;
   wire b_loop = route[`SCP_ROUTE_B_LOOP];
   wire apb_wr = psel & penable & pwrite;
   wire apb_rd = psel & penable & ~pwrite;
   wire known = (paddr == `SCP_OFF_BASE) | (paddr == `SCP_OFF_ROUTE) |
      (paddr == `SCP_OFF_RATE_A) | (paddr == `SCP_OFF_RATE_B) |
      (paddr == `SCP_OFF_STATUS);
   // upper six bits compared, low two free
   // gated by i/o request, blocked by memory request
   wire io_cycle = ~host_iorq_n & host_mreq_n & (~host_rd_n | ~host_wr_n);
   // bit for bit match against setting levels
   wire hit = io_cycle & (host_addr[7:2] == port_base_match_setting);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // closed = 0, open = 1; default b0h block
         port_base_match_setting <= `SCP_BASE_RESET;
         // a terminal; b modem, voltage signalling
         route <= `SCP_ROUTE_RESET;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         hit_seen <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~(paddr == `SCP_OFF_BASE | paddr == `SCP_OFF_ROUTE |
            paddr == `SCP_OFF_RATE_A | paddr == `SCP_OFF_RATE_B | paddr == `SCP_OFF_STATUS);
         if (apb_wr & pready & known) begin
            if (paddr == `SCP_OFF_BASE) port_base_match_setting <= pwdata[5:0];
            // only channel b holds a loop bit; loop apart from routing
            if (paddr == `SCP_OFF_ROUTE) route <= pwdata[2:0];
         end
         // sticky claim flag, cleared by reading status; a new claim wins
         if (hit) hit_seen <= 1'b1;
         else if (apb_rd & pready & paddr == `SCP_OFF_STATUS) hit_seen <= 1'b0;
         if (psel & ~penable & ~pwrite) begin
            case (paddr)
               `SCP_OFF_BASE: prdata <= {26'h0, port_base_match_setting};
               `SCP_OFF_ROUTE: prdata <= {29'h0, route};
               `SCP_OFF_RATE_A: prdata <= {28'h0, ra_code};
               `SCP_OFF_RATE_B: prdata <= {28'h0, rb_code};
               `SCP_OFF_STATUS: prdata <= {29'h0, hit_seen, rb_err, ra_err};
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // host decode
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_cs_n <= 1'b1;
         ctl_chan_b <= 1'b0;
         ctl_ctrl <= 1'b0;
      end else begin
         ctl_cs_n <= ~hit;
         // bit 1 channel, bit 0 control
         ctl_chan_b <= host_addr[1];
         ctl_ctrl <= host_addr[0];
      end
   end

   // ----------------------------------------
   // channels
   // ----------------------------------------
   // independent rate per channel
   scp_chan_route u_a (
      .pclk(pclk), .presetn(presetn), .modem(route[`SCP_ROUTE_A_MODEM]),
      .rate_select(chan_a_rate_select), .txd(a_txd), .rts(a_rts), .dtr(a_dtr),
      .pin2_in(a_pin_in[2]), .pin3_in(a_pin_in[3]), .pin4_in(a_pin_in[4]),
      .pin5_in(a_pin_in[5]), .pin6_in(a_pin_in[6]), .pin7_in(a_pin_in[7]),
      .pin_out(ra_out), .pin_oe(ra_oe), .rxd(ra_rxd), .cts(ra_cts), .dcd(ra_dcd),
      .rate_code(ra_code), .rate_err(ra_err));
   scp_chan_route u_b (
      .pclk(pclk), .presetn(presetn), .modem(route[`SCP_ROUTE_B_MODEM]),
      .rate_select(chan_b_rate_select), .txd(b_txd), .rts(b_rts), .dtr(b_dtr),
      .pin2_in(b_pin_in[2]), .pin3_in(b_pin_in[3]), .pin4_in(b_pin_in[4]),
      .pin5_in(b_pin_in[5]), .pin6_in(b_pin_in[6]), .pin7_in(b_pin_in[7]),
      .pin_out(rb_out), .pin_oe(rb_oe), .rxd(rb_rxd), .cts(rb_cts), .dcd(rb_dcd),
      .rate_code(rb_code), .rate_err(rb_err));

   // outputs registered once more so all come from flops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_pin_out <= 6'h00;
         a_pin_oe <= 6'h00;
         b_pin_out <= 6'h00;
         b_pin_oe <= 6'h00;
         a_rxd <= 1'b1;
         a_cts <= 1'b0;
         a_dcd <= 1'b0;
         b_rxd <= 1'b1;
         b_cts <= 1'b0;
         b_dcd <= 1'b0;
         a_rate_code <= 4'h0;
         b_rate_code <= 4'h0;
      end else begin
         a_pin_out <= ra_out;
         a_pin_oe <= ra_oe;
         a_rxd <= ra_rxd;
         a_cts <= ra_cts;
         a_dcd <= ra_dcd;
         a_rate_code <= ra_code;
         b_rate_code <= rb_code;
         // current loop: pin 2 tx, pin 4 rx, pin 6 dtr, returns passive
         if (b_loop) begin
            b_pin_out <= {1'b0, b_dtr, 1'b0, 1'b0, 1'b0, b_txd};
            b_pin_oe <= 6'b010001;
            b_rxd <= b_pin_in[4];
            b_cts <= 1'b0;
            b_dcd <= 1'b0;
         end else begin
            b_pin_out <= rb_out;
            b_pin_oe <= rb_oe;
            b_rxd <= rb_rxd;
            b_cts <= rb_cts;
            b_dcd <= rb_dcd;
         end
      end
   end
endmodule

// file: test/scp_chk.sv
// assertions on the port decode block's pins
// assumes it is bound to scp_port_decode and sees only its ports
module scp_chk (
   input wire pclk, // clock
   input wire presetn, // reset, active low
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pready, // apb ready
   input wire pslverr, // apb error
   input wire [7:0] host_addr, // host address
   input wire host_iorq_n, // host i/o request
   input wire host_mreq_n, // host memory request
   input wire host_rd_n, // host read
   input wire host_wr_n, // host write
   input wire ctl_cs_n, // controller select
   input wire ctl_chan_b, // channel pick
   input wire ctl_ctrl, // control pick
   input wire [9:0] chan_a_rate_select, // rate a
   input wire [9:0] chan_b_rate_select, // rate b
   input wire [3:0] a_rate_code, // code a
   input wire [3:0] b_rate_code // code b
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   function automatic [3:0] enc(input [9:0] s);
      integer i;
      enc = 4'h0;
      for (i = 0; i < 10; i = i + 1) if (s[i]) enc = i[3:0] + 4'h1;
   endfunction
   // ----------------------------------------
   // decode, apb answer and rate codes
   // ----------------------------------------
   sequence io_cyc;
      !host_iorq_n && host_mreq_n && !(host_rd_n && host_wr_n);
   endsequence
   sequence apb_setup;
      psel && !penable;
   endsequence
   cs_io_a: assert property (!ctl_cs_n |-> $past(!host_iorq_n && host_mreq_n)) else $error("select outside i/o");
   no_mem_a: assert property (!host_mreq_n |=> ctl_cs_n) else $error("select in memory cycle");
   chan_sel_a: assert property (!ctl_cs_n |-> ctl_chan_b == $past(host_addr[1])) else $error("bad channel");
   ctrl_sel_a: assert property (!ctl_cs_n |-> ctl_ctrl == $past(host_addr[0])) else $error("bad data pick");
   apb_ready_a: assert property (apb_setup |=> pready) else $error("no ready");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
   slverr_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   rate_a_a: assert property (($onehot(chan_a_rate_select) && $stable(chan_a_rate_select))[*4] |-> a_rate_code == enc(chan_a_rate_select)) else $error("rate a");
   rate_b_a: assert property (($onehot(chan_b_rate_select) && $stable(chan_b_rate_select))[*4] |-> b_rate_code == enc(chan_b_rate_select)) else $error("rate b");
   io_cover: cover property (io_cyc ##1 !ctl_cs_n);
endmodule
bind scp_port_decode scp_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .host_addr, .host_iorq_n, .host_mreq_n, .host_rd_n, .host_wr_n, .ctl_cs_n, .ctl_chan_b,
   .ctl_ctrl, .chan_a_rate_select, .chan_b_rate_select, .a_rate_code, .b_rate_code);

// file: test/scp_host_model.sv
// host processor i/o bus driver
// assumes start and stop are called right after a rising edge
module scp_host_model (
   output reg [7:0] host_addr, // address
   output reg host_iorq_n, // i/o request
   output reg host_mreq_n, // memory request
   output reg host_rd_n, // read strobe
   output reg host_wr_n // write strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      host_addr = 8'h00;
      {host_iorq_n, host_mreq_n, host_rd_n, host_wr_n} = 4'hf;
   end
   task start(input [7:0] a, input mem);
      host_addr <= a;
      host_iorq_n <= mem;
      host_mreq_n <= !mem;
      // odd ports write, even ports read, so both strobes are used
      host_rd_n <= a[0];
      host_wr_n <= ~a[0];
   endtask
   // released bus shows no stale address
   task stop;
      host_addr <= ~host_addr;
      {host_iorq_n, host_mreq_n, host_rd_n, host_wr_n} <= 4'hf;
   endtask
endmodule

// file: test/testbench.sv
// self-checking bench for the port decode block
// assumes the host model and the bound checker
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, a_txd = 1'b0;
   reg b_txd = 1'b0;
   wire a_cts, b_dcd;
   wire [7:2] b_pin_out, b_pin_oe;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0, rd;
   reg [9:0] chan_a_rate_select = 10'h200, chan_b_rate_select = 10'h200;
   reg [7:2] a_pin_in = 6'h00, b_pin_in = 6'h00;
   reg er;
   wire [31:0] prdata;
   wire pready, pslverr, ctl_cs_n, ctl_chan_b, ctl_ctrl, host_iorq_n, host_mreq_n;
   wire host_rd_n, host_wr_n, a_rxd, b_rxd;
   wire [7:0] host_addr;
   wire [7:2] a_pin_out, a_pin_oe;
   wire [3:0] a_rate_code, b_rate_code;
   integer n_errors = 0, num_checks = 0, cyc = 0, i;
   always #5 pclk = ~pclk;
   scp_host_model hm (.host_addr, .host_iorq_n, .host_mreq_n, .host_rd_n, .host_wr_n);
   scp_port_decode dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .host_addr, .host_iorq_n, .host_mreq_n, .host_rd_n, .host_wr_n,
      .ctl_cs_n, .ctl_chan_b, .ctl_ctrl, .chan_a_rate_select, .chan_b_rate_select, .a_txd,
      .a_rts(1'b0), .a_dtr(a_txd), .b_txd, .b_rts(1'b0), .b_dtr(b_txd), .a_pin_in,
      .b_pin_in, .a_pin_out, .a_pin_oe, .b_pin_out, .b_pin_oe, .a_rxd, .a_cts,
      .a_dcd(), .b_rxd, .b_cts(), .b_dcd, .a_rate_code, .b_rate_code);
   task check(input string what, input [31:0] got, input [31:0] exp);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // called just after a rising edge; answer taken at the edge that sees ready
   task apb(input [11:0] a, input w, input [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task host(input [7:0] a, input mem, input hit);
      hm.start(a, mem);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      check("cs_n", ctl_cs_n, !hit);
      if (hit) check("chan_ctrl", {ctl_chan_b, ctl_ctrl}, a[1:0]);
      @(posedge pclk);
      hm.stop;
      repeat (2) @(posedge pclk);
   endtask
   // pins pass two register stages; three edges leave them settled
   task settle;
      repeat (3) @(posedge pclk);
   endtask
   task t_regs;
      apb(12'h000, 1'b0, 32'h0);
      check("base", rd, 32'h2c);
      apb(12'h004, 1'b0, 32'h0);
      check("route", rd, 32'h2);
      apb(12'h014, 1'b0, 32'h0);
      check("unmapped", er, 1'b1);
   endtask
   task t_decode;
      for (i = 0; i < 4; i = i + 1) host(8'hb0 + i, 1'b0, 1'b1);
      host(8'haf, 1'b0, 1'b0);
      host(8'hb4, 1'b0, 1'b0);
      host(8'hb1, 1'b1, 1'b0);
      apb(12'h000, 1'b1, 32'h3f);
      apb(12'h000, 1'b0, 32'h0);
      check("base_wr", rd, 32'h3f);
      host(8'hfe, 1'b0, 1'b1);
      host(8'hb2, 1'b0, 1'b0);
      apb(12'h000, 1'b1, 32'h0);
      host(8'h03, 1'b0, 1'b1);
      apb(12'h010, 1'b0, 32'h0);
      check("claim_seen", rd, 32'h4);
      apb(12'h010, 1'b0, 32'h0);
      check("claim_clear", rd, 32'h0);
   endtask
   task t_rates;
      for (i = 0; i < 10; i = i + 1) begin
         chan_a_rate_select <= 10'h001 << i;
         chan_b_rate_select <= 10'h200 >> i;
         repeat (4) @(posedge pclk);
         apb(12'h008, 1'b0, 32'h0);
         check("rate_a", rd, i + 1);
         check("rate_a_out", a_rate_code, i + 1);
         apb(12'h00c, 1'b0, 32'h0);
         check("rate_b", rd, 10 - i);
         check("rate_b_out", b_rate_code, 10 - i);
      end
      chan_a_rate_select <= 10'h003;
      repeat (4) @(posedge pclk);
      apb(12'h008, 1'b0, 32'h0);
      check("rate_a_two", rd, 32'h0);
      check("rate_a_two_out", a_rate_code, 4'h0);
      apb(12'h010, 1'b0, 32'h0);
      check("rate_err", rd, 32'h1);
      chan_a_rate_select <= 10'h200;
   endtask
   task t_route;
      a_pin_in <= 6'h0a;
      b_pin_in <= 6'h11;
      a_txd <= 1'b1;
      b_txd <= 1'b1;
      settle;
      check("a_rxd_term", a_rxd, 1'b1);
      check("a_cts_term", a_cts, 1'b1);
      check("a_oe_term", {a_pin_oe[2], a_pin_out[2]}, 2'h3);
      check("a_pins_term", {a_pin_oe, a_pin_out}, 12'h551);
      check("b_rxd_modem", b_rxd, 1'b1);
      check("b_dcd_modem", b_dcd, 1'b1);
      check("b_pins_modem", {b_pin_oe, b_pin_out}, 12'haa2);
      apb(12'h004, 1'b1, 32'h3);
      settle;
      check("a_rxd_modem", a_rxd, 1'b0);
      check("a_oe_modem", a_pin_oe[2], 1'b0);
      check("a_cts_modem", a_cts, 1'b0);
      check("a_pins_modem", {a_pin_oe, a_pin_out}, 12'haa2);
      apb(12'h004, 1'b1, 32'h6);
      settle;
      check("b_rxd_loop", b_rxd, 1'b0);
      check("b_dcd_loop", b_dcd, 1'b0);
      check("b_pins_loop", {b_pin_oe, b_pin_out}, 12'h451);
      check("a_pins_back", {a_pin_oe, a_pin_out}, 12'h551);
   endtask
   task summarize;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         n_errors = n_errors + 1;
         summarize;
      end
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs;
      t_decode;
      t_rates;
      t_route;
      summarize;
   end
endmodule
